// ---- common/nfc_pkg.sv ----
// constants, types and command table for the flash command host.
// assumes one flash target whose die busy shows on a ready/busy pin.
package nfc_pkg;

  // command bytes
  localparam logic [7:0] OPC_READ       = 8'h00;
  localparam logic [7:0] OPC_READ_GO    = 8'h30;
  localparam logic [7:0] OPC_CACHE_RD   = 8'h31;
  localparam logic [7:0] OPC_CACHE_END  = 8'h3f;
  localparam logic [7:0] OPC_MOVE_GO    = 8'h35;
  localparam logic [7:0] OPC_PROG       = 8'h80;
  localparam logic [7:0] OPC_PROG_GO    = 8'h10;
  localparam logic [7:0] OPC_PROG_CACHE = 8'h15;
  localparam logic [7:0] OPC_PLANE_NEXT = 8'h11;
  localparam logic [7:0] OPC_MOVE_PROG  = 8'h85;
  localparam logic [7:0] OPC_ERASE      = 8'h60;
  localparam logic [7:0] OPC_ERASE_GO   = 8'hd0;
  localparam logic [7:0] OPC_ERASE_NEXT = 8'hd1;
  localparam logic [7:0] OPC_COL_RD     = 8'h06;
  localparam logic [7:0] OPC_COL_GO     = 8'he0;

  // address cycles
  localparam logic [2:0] NA_NONE    = 3'h0;
  localparam logic [2:0] NA_ROW     = 3'h3;
  localparam logic [2:0] NA_FULL    = 3'h5;
  localparam logic [2:0] ADDR_BYTES = 3'h5;
  localparam logic [2:0] ADDR_LAST  = 3'h4;
  localparam int         PLANE_BYTE = 2;
  localparam int         PLANE_BIT  = 7;

  // timing
  localparam int T_CLK_NS   = 8;
  localparam int T_PHASE_NS = 20;
  localparam int PH_CYC     = (T_PHASE_NS + T_CLK_NS - 1) / T_CLK_NS;
  localparam int T_ADL_NS   = 100;
  localparam int ADL_TICKS  =
    (T_ADL_NS + PH_CYC * T_CLK_NS - 1) / (PH_CYC * T_CLK_NS);
  localparam logic [3:0] PH_LAST  = 4'(PH_CYC - 1);
  localparam logic [2:0] ADL_LAST = 3'(ADL_TICKS - 1);

  typedef enum logic [1:0] {DM_NONE, DM_REQ, DM_OPT} nfc_dmode_t;

  typedef enum logic [4:0] {
    OP_NONE, OP_READ_PAGE, OP_CACHE_SEQ, OP_CACHE_RAND, OP_CACHE_LAST,
    OP_PROG, OP_PROG_CACHE, OP_ERASE, OP_MOVE_READ, OP_MOVE_PROG,
    OP_OTP_LOCK, OP_OTP_PROG, OP_OTP_READ, OP_TP_READ, OP_TP_MOVE_READ,
    OP_TP_COL_READ, OP_TP_PROG, OP_TP_PROG_CACHE, OP_TP_MOVE_PROG,
    OP_TP_ERASE
  } nfc_op_t;

  // gray along idle-cmd-addr-gap-data-mid-addr-gap-data-last
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_CMD1 = 4'h1, ST_ADR1 = 4'h3, ST_ADL1 = 4'h2,
    ST_DAT1 = 4'h6, ST_MID  = 4'h7, ST_ADR2 = 4'h5, ST_ADL2 = 4'h4,
    ST_DAT2 = 4'hc, ST_LAST = 4'hd
  } nfc_state_t;

  typedef struct packed {
    logic [7:0] first;
    logic [2:0] na;
    nfc_dmode_t dmode;
    logic       two_plane;
    logic [7:0] mid1;
    logic       use_mid1;
    logic [7:0] mid2;
    logic [7:0] last;
    logic       use_last;
  } nfc_desc_t;

  typedef struct packed {
    nfc_op_t         op;
    logic [4:0][7:0] addr_a;
    logic [4:0][7:0] addr_b;
    logic            with_data;
    logic            omit_mid;
  } nfc_req_t;

  typedef struct packed {
    logic       ce_n;
    logic       cle;
    logic       ale;
    logic       we_n;
    logic       re_n;
    logic       wp_n;
    logic [7:0] io_out;
    logic       io_oe;
  } nfc_pins_t;

  localparam nfc_pins_t PINS_IDLE = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1,
                                      8'h00, 1'b0};

  function automatic nfc_desc_t nfc_desc(input nfc_op_t op);
    nfc_desc_t d;
    d = '{OPC_READ, NA_NONE, DM_NONE, 1'b0, OPC_READ, 1'b0, OPC_READ,
          OPC_READ, 1'b0};
    case (op)
      OP_READ_PAGE, OP_OTP_READ: begin
        d = '{OPC_READ, NA_FULL, DM_NONE, 1'b0, OPC_READ, 1'b0, OPC_READ,
              OPC_READ_GO, 1'b1};
      end
      OP_CACHE_SEQ: d.first = OPC_CACHE_RD;
      OP_CACHE_LAST: d.first = OPC_CACHE_END;
      OP_CACHE_RAND: begin
        d = '{OPC_READ, NA_FULL, DM_NONE, 1'b0, OPC_READ, 1'b0, OPC_READ,
              OPC_CACHE_RD, 1'b1};
      end
      OP_PROG, OP_OTP_PROG, OP_PROG_CACHE, OP_OTP_LOCK: begin
        d = '{OPC_PROG, NA_FULL, DM_REQ, 1'b0, OPC_PLANE_NEXT, 1'b1,
              OPC_PROG, OPC_PROG_GO, 1'b1};
        if (op == OP_PROG_CACHE) d.last = OPC_PROG_CACHE;
        if (op == OP_OTP_LOCK) d.dmode = DM_NONE;
      end
      OP_ERASE: begin
        d = '{OPC_ERASE, NA_ROW, DM_NONE, 1'b0, OPC_ERASE_NEXT, 1'b1,
              OPC_ERASE, OPC_ERASE_GO, 1'b1};
      end
      OP_MOVE_READ: begin
        d = '{OPC_READ, NA_FULL, DM_NONE, 1'b0, OPC_READ, 1'b0, OPC_READ,
              OPC_MOVE_GO, 1'b1};
      end
      OP_MOVE_PROG: begin
        d = '{OPC_MOVE_PROG, NA_FULL, DM_OPT, 1'b0, OPC_PLANE_NEXT, 1'b1,
              OPC_MOVE_PROG, OPC_PROG_GO, 1'b1};
      end
      OP_TP_READ, OP_TP_MOVE_READ: begin
        d = '{OPC_READ, NA_FULL, DM_NONE, 1'b1, OPC_READ, 1'b0, OPC_READ,
              OPC_READ_GO, 1'b1};
        if (op == OP_TP_MOVE_READ) d.last = OPC_MOVE_GO;
      end
      OP_TP_COL_READ: begin
        d = '{OPC_COL_RD, NA_FULL, DM_NONE, 1'b0, OPC_READ, 1'b0, OPC_READ,
              OPC_COL_GO, 1'b1};
      end
      OP_TP_PROG, OP_TP_PROG_CACHE, OP_TP_MOVE_PROG: begin
        d = '{OPC_PROG, NA_FULL, DM_REQ, 1'b1, OPC_PLANE_NEXT, 1'b1,
              OPC_PROG, OPC_PROG_GO, 1'b1};
        if (op == OP_TP_PROG_CACHE) d.last = OPC_PROG_CACHE;
        if (op == OP_TP_MOVE_PROG) begin
          d.first = OPC_MOVE_PROG;
          d.mid2  = OPC_MOVE_PROG;
          d.dmode = DM_OPT;
        end
      end
      OP_TP_ERASE: begin
        d = '{OPC_ERASE, NA_ROW, DM_NONE, 1'b1, OPC_ERASE_NEXT, 1'b1,
              OPC_ERASE, OPC_ERASE_GO, 1'b1};
      end
      default: d.use_last = 1'b0;
    endcase
    return d;
  endfunction : nfc_desc

  function automatic logic nfc_plane(input logic [4:0][7:0] a);
    return a[PLANE_BYTE][PLANE_BIT];
  endfunction : nfc_plane

endpackage : nfc_pkg

// ---- hw/nfc_cmd_host.sv ----
// host side command sequencer for program, erase, move, otp and
// two-plane flash operations. assumes the status poller outside feeds
// the array ready bit and that otp mode entry is flagged on otp_mode_en.
//
// Contract
// R1 - cached program on busy array after cached program
// R2 - cached reads on busy array only after reads
// R3 - internal copy stays inside one plane
// R4 - copy read 35h, copy program 85h/10h, die ready
// R5 - otp commands only after otp mode entered
// R6 - otp program refused while any die busy
// R7 - otp read refused while any die busy
// R8 - otp lock refused while any die busy
// R9 - programs allowed while other dies busy
// R10 - two-plane column read only after two-plane read
// R11 - erase 60h/d0h, two-plane with optional d1h
// R12 - two-plane copy read and program, planes kept
// R13 - two-plane program 80h/11h/80h then 10h or 15h
// R14 - nothing starts on a busy die except caching; here caching is refused too while the synced r/b pin is low
`timescale 1ns/1ns
module nfc_cmd_host
  import nfc_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // operation request
  input  wire logic       req_valid,
  input  wire nfc_req_t   req,
  output logic            req_ready,
  output logic            req_done,
  output logic            req_refused,
  // data bytes for program operations
  input  wire logic       dat_valid,
  input  wire logic [7:0] dat_byte,
  input  wire logic       dat_last,
  output logic            dat_ready,
  // die state
  input  wire logic       array_ready_bit,
  input  wire logic       other_dies_busy,
  input  wire logic       otp_mode_en,
  // flash pins
  input  wire logic       rb_n_pin,
  output nfc_pins_t       pins
);

  nfc_state_t state;
  nfc_state_t n_state;
  nfc_req_t   cur;
  nfc_op_t    last_op;
  logic [2:0] idx;
  logic [2:0] n_idx;
  logic [3:0] div;
  logic       sub;
  logic       dat_on;
  logic       got_last;
  logic       src_plane_a;
  logic       src_plane_b;
  logic       rb_meta;
  logic       rb_sync;
  logic [7:0] drv_byte;
  logic       drv_cle;
  logic       drv_ale;

  wire nfc_desc_t d     = nfc_desc(cur.op);
  wire nfc_desc_t sd    = nfc_desc(req.op);
  wire logic [2:0] a_st = ADDR_BYTES - d.na;
  wire logic tick  = (div == PH_LAST);
  wire logic adl   = (state == ST_ADL1) || (state == ST_ADL2);
  wire logic step  = tick & sub & ~adl & ~dat_ready & (state != ST_IDLE);
  wire logic fire  = dat_valid & dat_ready;
  wire logic in_dat = (state == ST_DAT1) || (state == ST_DAT2);
  wire logic start = req_valid & req_ready;

  // permission checks on the request
  wire logic is_otp   = (req.op == OP_OTP_LOCK) || (req.op == OP_OTP_PROG)
                        || (req.op == OP_OTP_READ);
  wire logic is_cprog = (req.op == OP_PROG_CACHE)
                        || (req.op == OP_TP_PROG_CACHE);
  wire logic is_cread = (req.op == OP_CACHE_SEQ) || (req.op == OP_CACHE_RAND)
                        || (req.op == OP_CACHE_LAST);
  wire logic prev_cprog = (last_op == OP_PROG_CACHE)
                          || (last_op == OP_TP_PROG_CACHE);
  wire logic prev_read  = (last_op == OP_READ_PAGE)
                          || (last_op == OP_CACHE_SEQ)
                          || (last_op == OP_CACHE_RAND)
                          || (last_op == OP_CACHE_LAST);
  wire logic cache_ok = (is_cprog & prev_cprog)  // R1
                        | (is_cread & prev_read); // R2
  // die busy blocks all; busy array only lets caching pass
  wire logic busy_ok  = rb_sync & (array_ready_bit | cache_ok); // R14 R4 R9
  wire logic otp_ok   = ~is_otp | (otp_mode_en & ~other_dies_busy); // R5 R6 R7 R8
  wire logic col_ok   = (req.op != OP_TP_COL_READ)
                        || (last_op == OP_TP_READ)
                        || (last_op == OP_TP_COL_READ); // R10
  wire logic pl_a_ok  = nfc_plane(req.addr_a) == src_plane_a;
  wire logic pl_b_ok  = nfc_plane(req.addr_b) == src_plane_b;
  wire logic plane_ok = ((req.op != OP_MOVE_PROG) || pl_a_ok)           // R3
                        && ((req.op != OP_TP_MOVE_PROG)
                            || (pl_a_ok && pl_b_ok));                   // R12
  wire logic req_ok   = (req.op != OP_NONE) & busy_ok & otp_ok & col_ok
                        & plane_ok;
  wire logic take     = start & req_ok;
  wire logic s_dat    = (sd.dmode == DM_REQ)
                        || ((sd.dmode == DM_OPT) && req.with_data);

  // d1h may be left out of a two-plane erase
  wire logic mid1_on = d.use_mid1 & ~(cur.omit_mid & (cur.op == OP_TP_ERASE)); // R11
  wire nfc_state_t st_end = d.use_last ? ST_LAST : ST_IDLE;
  wire nfc_state_t h1_st  = d.two_plane ? ST_MID : st_end;   // R12 R13
  wire logic [2:0] h1_idx = mid1_on ? 3'h0 : 3'h1;

  // where the byte engine goes once the current byte is written
  always_comb begin
    n_state = ST_IDLE;
    n_idx   = '0;
    case (state)
      ST_CMD1: begin
        if (d.na != NA_NONE) begin
          n_state = ST_ADR1;
          n_idx   = a_st;
        end else begin
          n_state = st_end;
        end
      end
      ST_ADR1: begin
        if (idx != ADDR_LAST) begin
          n_state = ST_ADR1;
          n_idx   = idx + 3'h1;
        end else if (dat_on) begin
          n_state = ST_ADL1;
        end else begin
          n_state = h1_st;
          n_idx   = h1_idx;
        end
      end
      ST_DAT1: begin
        n_state = h1_st;
        n_idx   = h1_idx;
      end
      ST_MID: begin
        if (idx == 3'h0) begin
          n_state = ST_MID;
          n_idx   = 3'h1;
        end else begin
          n_state = ST_ADR2;
          n_idx   = a_st;
        end
      end
      ST_ADR2: begin
        if (idx != ADDR_LAST) begin
          n_state = ST_ADR2;
          n_idx   = idx + 3'h1;
        end else if (dat_on) begin
          n_state = ST_ADL2;
        end else begin
          n_state = st_end;
        end
      end
      ST_DAT2: n_state = st_end;
      default: n_state = ST_IDLE;
    endcase
  end

  // byte and latch strobes for the next state
  always_comb begin
    drv_byte = '0;
    drv_cle  = 1'b0;
    drv_ale  = 1'b0;
    case (n_state)
      ST_ADR1: begin
        drv_byte = cur.addr_a[n_idx];
        drv_ale  = 1'b1;
      end
      ST_MID: begin
        drv_byte = (n_idx == 3'h0) ? d.mid1 : d.mid2;
        drv_cle  = 1'b1;
      end
      ST_ADR2: begin
        drv_byte = cur.addr_b[n_idx];
        drv_ale  = 1'b1;
      end
      ST_LAST: begin
        drv_byte = d.last;
        drv_cle  = 1'b1;
      end
      default: drv_byte = '0;
    endcase
  end

  wire logic fin    = step & ~(in_dat & ~got_last) & (n_state == ST_IDLE);
  wire logic to_adl = step & ((n_state == ST_ADL1) || (n_state == ST_ADL2));
  wire logic nxt    = step & ~(in_dat & ~got_last) & ~fin & ~to_adl;
  wire logic want   = step & in_dat & ~got_last;
  wire logic adl_end = adl & tick & (idx == ADL_LAST);

  // ready/busy pin crosses in from the flash
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rb_meta <= 1'b0;
      rb_sync <= 1'b0;
    end else begin
      rb_meta <= rb_n_pin;
      rb_sync <= rb_meta;
    end
  end

  // phase divider restarts on every new byte so low time is full
  always_ff @(posedge clk_sys) begin
    if (rst || take || fire || nxt || tick || state == ST_IDLE)
      div <= '0;
    else
      div <= div + 4'h1;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= ST_IDLE;
      idx   <= '0;
      sub   <= 1'b1;
    end else if (take) begin
      state <= ST_CMD1;
      idx   <= '0;
      sub   <= 1'b0;
    end else if (fire) begin
      sub <= 1'b0;
    end else if (adl) begin
      if (adl_end) begin
        state <= (state == ST_ADL1) ? ST_DAT1 : ST_DAT2;
        idx   <= '0;
      end else if (tick) begin
        idx <= idx + 3'h1;
      end
    end else if (tick && !sub) begin
      sub <= 1'b1;
    end else if (step && !want) begin
      state <= n_state;
      idx   <= n_idx;
      sub   <= ~nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pins <= PINS_IDLE;
    end else if (take) begin
      pins.ce_n   <= 1'b0;
      pins.cle    <= 1'b1;
      pins.ale    <= 1'b0;
      pins.we_n   <= 1'b0;
      pins.io_out <= sd.first;
      pins.io_oe  <= 1'b1;
    end else if (fire) begin
      pins.cle    <= 1'b0;
      pins.ale    <= 1'b0;
      pins.we_n   <= 1'b0;
      pins.io_out <= dat_byte;
    end else if (tick && !sub && !adl && state != ST_IDLE) begin
      pins.we_n <= 1'b1;
    end else if (fin) begin
      pins <= PINS_IDLE;
    end else if (to_adl) begin
      pins.ale <= 1'b0;
    end else if (nxt) begin
      pins.cle    <= drv_cle;
      pins.ale    <= drv_ale;
      pins.we_n   <= 1'b0;
      pins.io_out <= drv_byte;
    end
  end

  // request bookkeeping and data handshake
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cur         <= '0;
      dat_on      <= 1'b0;
      got_last    <= 1'b0;
      dat_ready   <= 1'b0;
      req_ready   <= 1'b1;
      req_done    <= 1'b0;
      req_refused <= 1'b0;
      last_op     <= OP_NONE;
      src_plane_a <= 1'b0;
      src_plane_b <= 1'b0;
    end else begin
      req_done    <= fin;
      req_refused <= start & ~req_ok;
      if (take) begin
        cur       <= req;
        dat_on    <= s_dat;
        req_ready <= 1'b0;
        if (req.op == OP_MOVE_READ || req.op == OP_TP_MOVE_READ) begin
          src_plane_a <= nfc_plane(req.addr_a); // R3 R4
          src_plane_b <= nfc_plane(req.addr_b); // R12
        end
      end
      if (fin) begin
        req_ready <= 1'b1;
        last_op   <= cur.op;
      end
      if (adl_end || want)
        dat_ready <= 1'b1;
      else if (fire)
        dat_ready <= 1'b0;
      if (adl_end || take)
        got_last <= 1'b0;
      else if (fire)
        got_last <= dat_last;
    end
  end

endmodule : nfc_cmd_host

// ---- verification/nfc_cmd_host_sva.sv ----
// checker for the flash command host, bound onto its ports.
// assumes one clock domain and a synchronous active high reset.
`timescale 1ns/1ns
module nfc_cmd_host_sva
  import nfc_pkg::*;
(
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       rst,
  // request and data
  input wire logic       req_valid,
  input wire nfc_req_t   req,
  input wire logic       req_ready,
  input wire logic       req_done,
  input wire logic       req_refused,
  input wire logic       dat_valid,
  input wire logic [7:0] dat_byte,
  input wire logic       dat_ready,
  // die state and pins
  input wire logic       other_dies_busy,
  input wire logic       otp_mode_en,
  input wire logic       rb_n_pin,
  input wire nfc_pins_t  pins
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic take;
  logic otp_op;
  assign take   = req_valid && req_ready;
  assign otp_op = req.op inside {OP_OTP_LOCK, OP_OTP_PROG, OP_OTP_READ};

  // three samples low so the pin sync has surely seen it
  a_busy_die_refused: assert property (
    take && !rb_n_pin && !$past(rb_n_pin) && !$past(rb_n_pin, 2)
    |=> req_refused) else $error("request on busy die went out");
  a_otp_mode_gate: assert property (
    take && otp_op && !otp_mode_en |=> req_refused)
    else $error("otp op went out without otp mode");
  a_otp_busy_gate: assert property (
    take && otp_op && other_dies_busy |=> req_refused)
    else $error("otp op went out while another die busy");
  a_erase_opcode: assert property (
    take && req.op == OP_ERASE ##1 !req_ready
    |-> pins.cle && !pins.ce_n && pins.io_out == 8'h60)
    else $error("erase did not open with its command");
  a_move_opcode: assert property (
    take && req.op == OP_MOVE_PROG ##1 !req_ready
    |-> pins.cle && !pins.ce_n && pins.io_out == 8'h85)
    else $error("move program did not open with its command");
  a_colrd_opcode: assert property (
    take && req.op == OP_TP_COL_READ ##1 !req_ready
    |-> pins.cle && pins.io_out == 8'h06)
    else $error("column read did not open with its command");
  a_cache_opcode: assert property (
    take && req.op == OP_CACHE_SEQ ##1 !req_ready
    |-> pins.cle && pins.io_out == 8'h31)
    else $error("cache read did not send its command");
  a_data_byte_out: assert property (
    dat_valid && dat_ready |=> pins.io_out == $past(dat_byte)
    && !pins.cle && !pins.ale && pins.io_oe)
    else $error("data byte not driven as data");
  a_done_pins_idle: assert property (
    req_done |-> pins.ce_n && pins.we_n && !pins.io_oe && !pins.cle
    && !pins.ale) else $error("pins not released after command");
  a_refused_no_cmd: assert property (
    req_refused |-> pins.ce_n && req_ready)
    else $error("refused request still selected the die");
  a_read_wp_high: assert property (
    pins.re_n && pins.wp_n) else $error("read or protect strobe driven");
endmodule : nfc_cmd_host_sva

// ---- verification/nfc_dev_model.sv ----
// behavioural flash die: logs each latched byte, shows busy on r/b.
// assumes bytes latch on the rising write strobe while selected.
`timescale 1ns/1ns
module nfc_dev_model
  import nfc_pkg::*;
(
  // pins from the host
  input  wire nfc_pins_t pins,
  // busy request from the bench
  input  wire logic      busy,
  output logic           rb_n
);
  // entry is {command latch, address latch, byte}
  logic [9:0] log_q[$];
  // driven high whenever busy is low, so never left floating
  assign rb_n = !busy;
  always @(posedge pins.we_n)
    if (!pins.ce_n)
      log_q.push_back({pins.cle, pins.ale, pins.io_out});
endmodule : nfc_dev_model

// ---- verification/tb_top.sv ----
// self-checking bench for the flash command host against a die model.
// assumes the checker and die model files are compiled before it.
`timescale 1ns/1ns
module tb_top
  import nfc_pkg::*;
;
  logic       clk_sys = 1'b0;
  logic       rst = 1'b1;
  logic       req_valid = 1'b0;
  nfc_req_t   req = '0;
  logic       dat_valid = 1'b0;
  logic [7:0] dat_byte = 8'h00;
  logic       dat_last = 1'b0;
  logic       arr_ready = 1'b1;
  logic       odb = 1'b0;
  logic       otp = 1'b0;
  logic       busy = 1'b0;
  logic       omit = 1'b0;
  logic       req_ready;
  logic       req_done;
  logic       req_refused;
  logic       dat_ready;
  logic       rb_n;
  nfc_pins_t  pins;
  int         n_fail = 0;
  int         samples_checked = 0;
  logic [9:0] exp_q[$];

  always #4 clk_sys = ~clk_sys;

  nfc_cmd_host dut (
    .clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .req_done(req_done), .req_refused(req_refused),
    .dat_valid(dat_valid), .dat_byte(dat_byte), .dat_last(dat_last),
    .dat_ready(dat_ready), .array_ready_bit(arr_ready), .other_dies_busy(odb),
    .otp_mode_en(otp), .rb_n_pin(rb_n), .pins(pins));
  nfc_dev_model dev (.pins(pins), .busy(busy), .rb_n(rb_n));

  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic print_verdict();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [9:0] got, input logic [9:0] want);
    samples_checked++;
    if (got !== want) begin
      n_fail++;
      $display("mismatch at %0t: got %h want %h", $time, got, want);
    end
  endtask : chk

  task automatic ec(input logic [7:0] c);
    exp_q.push_back({2'b10, c});
  endtask : ec

  // command, trailing n address bytes, nd data bytes from index d0
  task automatic ex(input logic [7:0] c, input logic [7:0] a, input int n,
                    input int d0 = 0, input int nd = 0);
    ec(c);
    for (int k = 5 - n; k < 5; k++)
      exp_q.push_back({2'b01, a + 8'(k)});
    for (int k = d0; k < d0 + nd; k++)
      exp_q.push_back({2'b00, 8'ha0 + 8'(k)});
  endtask : ex

  function automatic logic [4:0][7:0] adr(input logic [7:0] a);
    for (int k = 0; k < 5; k++)
      adr[k] = a + 8'(k);
  endfunction : adr

  // nd data bytes per half over nh halves; ok means accepted
  task automatic run(input nfc_op_t op, input logic ok, input logic [7:0] a,
                     input logic [7:0] b = 8'h0, input int nd = 0,
                     input int nh = 1);
    int i;
    logic tk;
    logic dn;
    logic rf;
    i = 0;
    tk = 1'b0;
    dn = 1'b0;
    rf = 1'b0;
    dev.log_q.delete();
    for (int k = 0; k < 99 && req_ready !== 1'b1; k++)
      tick();
    req = '{op, adr(a), adr(b), nd > 0, omit};
    req_valid = 1'b1;
    tick();
    req_valid = 1'b0;
    for (int k = 0; k < 3000 && !(dn || rf); k++) begin
      i += int'(tk);
      dn = req_done;
      rf = req_refused;
      dat_valid = i < nd * nh;
      dat_byte = 8'ha0 + 8'(i);
      dat_last = nd > 0 && i % nd == nd - 1;
      tk = dat_valid && dat_ready;
      tick();
    end
    dat_valid = 1'b0;
    chk({9'h0, rf}, {9'h0, !ok});
    chk({9'h0, dn}, {9'h0, ok});
    chk(10'(dev.log_q.size()), 10'(exp_q.size()));
    foreach (exp_q[j])
      if (j < dev.log_q.size()) chk(dev.log_q[j], exp_q[j]);
    exp_q.delete();
  endtask : run

  task automatic t_erase();
    ex(8'h60, 8'h10, 3);
    ec(8'hd0);
    run(OP_ERASE, 1'b1, 8'h10);
    ex(8'h60, 8'h10, 3);
    ec(8'hd1);
    ex(8'h60, 8'h90, 3);
    ec(8'hd0);
    run(OP_TP_ERASE, 1'b1, 8'h10, 8'h90);
    omit = 1'b1;
    ex(8'h60, 8'h10, 3);
    ex(8'h60, 8'h90, 3);
    ec(8'hd0);
    run(OP_TP_ERASE, 1'b1, 8'h10, 8'h90);
    omit = 1'b0;
  endtask : t_erase

  // programs still go out while other dies are busy
  task automatic t_prog();
    odb = 1'b1;
    ex(8'h80, 8'h20, 5, 0, 3);
    ec(8'h10);
    run(OP_PROG, 1'b1, 8'h20, 8'h0, 3);
    ex(8'h80, 8'h20, 5, 0, 2);
    ec(8'h11);
    ex(8'h80, 8'ha0, 5, 2, 2);
    ec(8'h15);
    run(OP_TP_PROG_CACHE, 1'b1, 8'h20, 8'ha0, 2, 2);
    odb = 1'b0;
  endtask : t_prog

  task automatic t_cache();
    ex(8'h00, 8'h30, 5);
    ec(8'h30);
    run(OP_READ_PAGE, 1'b1, 8'h30);
    arr_ready = 1'b0;
    ec(8'h31);
    run(OP_CACHE_SEQ, 1'b1, 8'h0);
    ex(8'h00, 8'h38, 5);
    ec(8'h31);
    run(OP_CACHE_RAND, 1'b1, 8'h38);
    ec(8'h3f);
    run(OP_CACHE_LAST, 1'b1, 8'h0);
    run(OP_PROG_CACHE, 1'b0, 8'h40);
    arr_ready = 1'b1;
    ex(8'h80, 8'h40, 5, 0, 1);
    ec(8'h15);
    run(OP_PROG_CACHE, 1'b1, 8'h40, 8'h0, 1);
    arr_ready = 1'b0;
    ex(8'h80, 8'h48, 5, 0, 1);
    ec(8'h15);
    run(OP_PROG_CACHE, 1'b1, 8'h48, 8'h0, 1);
    run(OP_CACHE_RAND, 1'b0, 8'h50);
    run(OP_PROG, 1'b0, 8'h50);
    arr_ready = 1'b1;
  endtask : t_cache

  task automatic t_otp();
    run(OP_OTP_PROG, 1'b0, 8'h60);
    otp = 1'b1;
    odb = 1'b1;
    run(OP_OTP_READ, 1'b0, 8'h60);
    run(OP_OTP_LOCK, 1'b0, 8'h60);
    run(OP_OTP_PROG, 1'b0, 8'h60);
    odb = 1'b0;
    ex(8'h80, 8'h60, 5);
    ec(8'h10);
    run(OP_OTP_LOCK, 1'b1, 8'h60);
    ex(8'h80, 8'h60, 5, 0, 2);
    ec(8'h10);
    run(OP_OTP_PROG, 1'b1, 8'h60, 8'h0, 2);
    ex(8'h00, 8'h60, 5);
    ec(8'h30);
    run(OP_OTP_READ, 1'b1, 8'h60);
    otp = 1'b0;
  endtask : t_otp

  // move program must stay in the plane its read came from
  task automatic t_move();
    ex(8'h00, 8'h10, 5);
    ec(8'h35);
    run(OP_MOVE_READ, 1'b1, 8'h10);
    run(OP_MOVE_PROG, 1'b0, 8'h90);
    ex(8'h85, 8'h20, 5, 0, 1);
    ec(8'h10);
    run(OP_MOVE_PROG, 1'b1, 8'h20, 8'h0, 1);
    busy = 1'b1;
    repeat (3) tick();
    run(OP_MOVE_READ, 1'b0, 8'h10);
    busy = 1'b0;
    repeat (3) tick();
  endtask : t_move

  task automatic t_tplane();
    run(OP_TP_COL_READ, 1'b0, 8'h10);
    ex(8'h00, 8'h10, 5);
    ex(8'h00, 8'h90, 5);
    ec(8'h30);
    run(OP_TP_READ, 1'b1, 8'h10, 8'h90);
    ex(8'h06, 8'h90, 5);
    ec(8'he0);
    run(OP_TP_COL_READ, 1'b1, 8'h90);
    ex(8'h00, 8'h10, 5);
    ex(8'h00, 8'h90, 5);
    ec(8'h35);
    run(OP_TP_MOVE_READ, 1'b1, 8'h10, 8'h90);
    run(OP_TP_MOVE_PROG, 1'b0, 8'h90, 8'h10);
    ex(8'h85, 8'h20, 5);
    ec(8'h11);
    ex(8'h85, 8'ha0, 5);
    ec(8'h10);
    run(OP_TP_MOVE_PROG, 1'b1, 8'h20, 8'ha0);
  endtask : t_tplane

  initial begin
    tick();
    tick();
    rst = 1'b0;
    repeat (3) tick();
    t_erase();
    t_prog();
    t_cache();
    t_otp();
    t_move();
    t_tplane();
    print_verdict();
  end

  // whole run needs well under a tenth of this
  initial begin
    #400000;
    n_fail++;
    print_verdict();
  end
endmodule : tb_top

bind nfc_cmd_host nfc_cmd_host_sva u_sva (
  .clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req(req),
  .req_ready(req_ready), .req_done(req_done), .req_refused(req_refused),
  .dat_valid(dat_valid), .dat_byte(dat_byte), .dat_ready(dat_ready),
  .other_dies_busy(other_dies_busy), .otp_mode_en(otp_mode_en),
  .rb_n_pin(rb_n_pin), .pins(pins));
